/* inc/seq_pkg.sv */
package seq_pkg;
   // ==========================================
   // Timing
   // ==========================================
   localparam int unsigned clk_hz = 25000000;
   localparam int unsigned init_min_ms = 100;
   localparam int unsigned init_min_cycles = (clk_hz / 1000) * init_min_ms;
   localparam int unsigned park_max_us = 500;
   localparam int unsigned park_max_cycles = (clk_hz / 1000000) * park_max_us;
   localparam int unsigned glitch_ns = 150;
   localparam int unsigned glitch_cycles = (glitch_ns * 25 + 999) / 1000; // Round up at 25 MHz
   localparam int unsigned park_steps = 16;

   // ==========================================
   // States
   // ==========================================
   typedef enum logic [2:0] {st_pll, st_load, st_wait, st_run, st_park, st_parked} seq_state_t;

   // Outputs heading to board pins: value and enable
   typedef struct packed {
      logic power_en;
      logic led_on;
      logic led_sel_lo;
      logic led_sel_hi;
      logic flash_clk;
      logic flash_out;
      logic flash_cs_n;
   } pin_group_t;
endpackage

/* design/park_filter.sv */
`timescale 1ns/1ps
module park_filter #(
   parameter int unsigned stable_cycles = 4
) (
   input wire logic clk, // Reference clock
   input wire logic arst_n, // Async reset, active low
   input wire logic ce, // Clock enable
   input wire logic din, // Synchronised park level
   output logic dout // Filtered park level
);
   logic [7:0] cnt_r;

   // ==========================================
   // Glitch filter
   // ==========================================
   // Level must hold for stable_cycles before output follows; slow edges ring out
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 8'h00;
         dout <= 1'b0;
      end else if (ce) begin
         if (din == dout) begin
            cnt_r <= 8'h00;
         end else if (cnt_r >= 8'(stable_cycles - 1)) begin
            cnt_r <= 8'h00;
            dout <= din; // R14
         end else begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule

/* design/reset_park_sequencer.sv */
// How it works
// R01: After reset release the busy status output goes high at once.
// R02: Initialisation waits for PLL lock, then loads configuration from flash.
// R03: Busy drops when initialisation ends, no sooner than 100 ms after release.
// R04: Host may send commands on busy low or its own 100 ms timeout.
// R05: Monitor holds reset until supplies valid, park high, clocks stable.
// R06: Host drives park high within 500 us of reset release.
// R07: In reset, outputs inactive and two-way pins are inputs.
// R08: In reset, power, LED and flash outputs are released to high impedance.
// R09: On reset release every pin becomes active.
// R10: Falling park edge starts the park sequence, finished within 500 us.
// R11: Host waits 500 us after park low before asserting reset.
// R12: Host waits 100 ms after power enable low before removing 1.8 V supply.
// R13: Clock runs and reset stays high 500 us after park falls.
// R14: Park input filter ignores transitions lasting up to 150 ns.
// R15: Reset release and park are synchronised before the state machine uses them.
`timescale 1ns/1ps
module reset_park_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned init_cycles = seq_pkg::init_min_cycles,
   parameter int unsigned park_cycles = seq_pkg::park_max_cycles
) (
   input wire logic clk, // Reference clock, 25 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic ce, // Clock enable
   input wire logic park_in, // Park request, low parks
   input wire logic pll_locked, // PLL lock indication
   input wire logic flash_load_done, // Self-load finished
   output logic flash_load_start, // Pulse: begin self-load
   output logic init_status_pin, // Busy, high while initialising
   output logic init_status_pin_oe, // Drive enable of busy pin
   output seq_pkg::pin_group_t pin_out, // Values of power, LED, flash pins
   output seq_pkg::pin_group_t pin_oe, // Drive enables of those pins
   output logic parked // Mirrors parked
);
   import seq_pkg::*;

   logic rst_s1_r, rst_s2_r;
   logic park_s1_r, park_s2_r;
   logic park_f;
   logic park_f_d_r;
   seq_state_t state_r;
   logic [31:0] init_cnt_r;
   logic [31:0] park_cnt_r;
   logic [3:0] step_r;

   // ==========================================
   // Decode helpers
   // ==========================================
   // True while the park sequence owns the outputs; a fresh fall is ignored then
   function automatic logic is_parking(input seq_state_t s);
      return s == st_park || s == st_parked;
   endfunction

   // True while the busy status must stand high; also gates the LED on value
   function automatic logic is_busy(input seq_state_t s);
      return s != st_run;
   endfunction

   // ==========================================
   // Synchronisers
   // ==========================================
   // Reset released into clock domain; assertion is async, deassertion synced
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1; // R15
         rst_s2_r <= rst_s1_r;
      end
   end

   // Park level, first stage read only by second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         park_s1_r <= 1'b0;
         park_s2_r <= 1'b0;
      end else if (ce) begin
         park_s1_r <= park_in; // R15
         park_s2_r <= park_s1_r;
      end
   end

   park_filter #(
      .stable_cycles(glitch_cycles)
   ) u_filter (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .din(park_s2_r),
      .dout(park_f)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         park_f_d_r <= 1'b0;
      end else if (ce) begin
         park_f_d_r <= park_f;
      end
   end

   // ==========================================
   // Sequencing state machine
   // ==========================================
   // Park falling edge overrides everything once running; init still parks if asked
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= st_pll;
      end else if (ce && rst_s2_r) begin
         // Falling edge of the filtered level only; a rise after reset is harmless
         if (park_f_d_r && !park_f && !is_parking(state_r)) begin
            state_r <= st_park; // R10
         end else begin
            unique case (state_r)
               st_pll: if (pll_locked) state_r <= st_load; // R02
               st_load: if (flash_load_done) state_r <= st_wait; // R02
               st_wait: if (init_cnt_r >= init_cycles) state_r <= st_run; // R03
               st_run: state_r <= st_run;
               st_park: if (step_r == 4'(park_steps - 1) || park_cnt_r >= park_cycles - 1) state_r <= st_parked;
               st_parked: if (park_f) state_r <= st_pll;
            endcase
         end
      end
   end

   // Cycles since reset release; the 100 ms floor is counted even during flash load
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         init_cnt_r <= 32'h0;
      end else if (ce && rst_s2_r && init_cnt_r < init_cycles) begin
         init_cnt_r <= init_cnt_r + 32'h1; // R03
      end
   end

   // Park budget counter, stepping the mirror settle in park_steps stages
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         park_cnt_r <= 32'h0;
         step_r <= 4'h0;
      end else if (ce) begin
         if (state_r == st_park) begin
            park_cnt_r <= park_cnt_r + 32'h1; // R10
            if (park_cnt_r[3:0] == 4'hf) step_r <= step_r + 4'h1;
         end else begin
            park_cnt_r <= 32'h0;
            step_r <= 4'h0;
         end
      end
   end

   // ==========================================
   // Outputs
   // ==========================================
   // Flash load kick one cycle on entering load
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flash_load_start <= 1'b0;
      end else if (ce) begin
         flash_load_start <= rst_s2_r && state_r == st_pll && pll_locked; // R02
      end
   end

   // Busy status; high from first cycle after release, low at run
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         init_status_pin <= 1'b0; // R07
         init_status_pin_oe <= 1'b0;
      end else if (ce) begin
         init_status_pin_oe <= 1'b1; // R09
         // Parking raises busy again so the host stops sending commands
         init_status_pin <= is_busy(state_r); // R01 R03
      end
   end

   // Pin enables released in reset so board pulls decide the level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_oe <= '0; // R08
      end else if (ce) begin
         pin_oe <= '1; // R09
      end
   end

   // Pin values; power up except when parked, LEDs only once running, flash chip select idle high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= '{default: 1'b0, flash_cs_n: 1'b1}; // R07
      end else if (ce) begin
         // Power stays up through the park steps so mirrors can settle
         pin_out.power_en <= state_r != st_parked;
         pin_out.led_on <= !is_busy(state_r);
         // Selects, flash clock and data idle here, chip select low in load; the self-load engine owns them elsewhere
         pin_out.led_sel_lo <= 1'b0;
         pin_out.led_sel_hi <= 1'b0;
         pin_out.flash_clk <= 1'b0;
         pin_out.flash_out <= 1'b0;
         pin_out.flash_cs_n <= state_r != st_load;
      end
   end

   // Parked flag; rises on the same edge as power enable falls
   // Limitation: a restart from parked clears it before init completes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         parked <= 1'b0;
      end else if (ce) begin
         parked <= state_r == st_parked; // R10
      end
   end
endmodule

/* test/park_seq_sva.sv */
`timescale 1ns/1ps
// ====================
// Sequencer checks
module park_seq_sva
   import seq_pkg::*;
#(parameter int unsigned init_cycles = 100) (
   input wire logic clk, // Clock
   input wire logic arst_n, // Reset
   input wire logic park_in, // Park
   input wire logic pll_locked, // Lock
   input wire logic flash_load_start, // Load pulse
   input wire logic init_status_pin, // Busy
   input wire logic init_status_pin_oe, // Busy enable
   input wire seq_pkg::pin_group_t pin_out, // Values
   input wire seq_pkg::pin_group_t pin_oe, // Enables
   input wire logic parked // Parked
);
   int unsigned age;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // Saturating age since release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) age <= 0;
      else if (age < init_cycles) age <= age + 1;
   end
   busy_rise_a: assert property ($rose(arst_n) |=> init_status_pin && init_status_pin_oe)
      else $error("busy not raised");
   load_order_a: assert property (flash_load_start |-> $past(pll_locked))
      else $error("load before lock");
   busy_min_a: assert property ($fell(init_status_pin) |-> age == init_cycles)
      else $error("busy fell early");
   // Two low edges: outputs may still be unknown at the very first edge
   reset_idle_a:
      assert property (disable iff (1'b0) !arst_n ##1 !arst_n |->
         pin_out == 7'h01 && !init_status_pin && !init_status_pin_oe && !parked) else $error("reset values");
   reset_hiz_a:
      assert property (disable iff (1'b0) !arst_n ##1 !arst_n |-> pin_oe == 7'h00) else $error("pins driven");
   pins_on_a: assert property ($past(arst_n) |-> pin_oe == 7'h7f && init_status_pin_oe)
      else $error("pins idle");
   park_done_a: assert property ($fell(park_in) ##1 !park_in [*7] |-> ##[1:330] parked)
      else $error("park late");
   park_glitch_a: assert property ($fell(park_in) ##[1:3] $rose(park_in) |-> ##300 !parked)
      else $error("glitch parked");
   c_busy: cover property ($fell(init_status_pin));
   c_park: cover property ($rose(parked));
   c_load: cover property (flash_load_start);
endmodule
bind reset_park_sequencer park_seq_sva #(.init_cycles(init_cycles)) i_park_seq_sva (.clk, .arst_n, .park_in,
   .pll_locked, .flash_load_start, .init_status_pin, .init_status_pin_oe, .pin_out, .pin_oe, .parked);

/* test/boot_peer.sv */
`timescale 1ns/1ps
// ====================
// Lock and self-load responder
module boot_peer (
   input wire logic clk, // Clock
   input wire logic arst_n, // Reset
   input wire logic [7:0] lag, // Answer delay
   input wire logic start, // Load request
   output logic locked, // PLL lock
   output logic done // Load done pulse
);
   logic [7:0] n;
   logic [7:0] m;
   // Delay is an input so one run sees prompt and slow answers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         n <= 8'h00;
         m <= 8'hff;
         locked <= 1'b0;
         done <= 1'b0;
      end else begin
         if (n < lag) n <= n + 8'h01;
         locked <= (n >= lag);
         if (start) m <= 8'h00;
         else if (m < 8'hff) m <= m + 8'h01;
         done <= (m == lag);
      end
   end
endmodule

/* test/reset_park_sequencer_tb.sv */
`timescale 1ns/1ps
// ====================
// Sequencer bench
module reset_park_sequencer_tb;
   import seq_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic park_in = 1'b1;
   logic [7:0] lag = 8'h02;
   logic lock, ld_done, ld_go, busy, busy_oe, parked;
   pin_group_t pin_out, pin_oe;
   int errors = 0;
   int n_checks = 0;
   int t;
   // 25 MHz clock
   always #20 clk = ~clk;
   reset_park_sequencer #(.init_cycles(100), .park_cycles(300)) i_reset_park_sequencer (.clk, .arst_n,
      .ce(1'b1), .park_in, .pll_locked(lock), .flash_load_done(ld_done), .flash_load_start(ld_go),
      .init_status_pin(busy), .init_status_pin_oe(busy_oe), .pin_out, .pin_oe, .parked);
   boot_peer i_boot_peer (.clk, .arst_n, .lag, .start(ld_go), .locked(lock), .done(ld_done));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset with park high, release, wait for busy to drop
   task automatic boot(input logic [7:0] l);
      lag = l;
      arst_n = 1'b0;
      park_in = 1'b1;
      cyc(2);
      chk({busy_oe, busy, parked, pin_out, pin_oe}, 17'h00080);
      arst_n = 1'b1;
      cyc(2);
      chk({busy_oe, busy, pin_oe}, 9'h1ff);
      t = 2;
      while (busy !== 1'b0 && t < 2000) begin
         cyc(1);
         t++;
      end
      chk({t >= 100, busy, pin_out.led_on, pin_out.flash_cs_n}, 4'b1011);
   endtask
   // 120 ns low pulse stays under the filter span
   task automatic glitch;
      park_in = 1'b0;
      cyc(3);
      park_in = 1'b1;
      cyc(400);
      chk({parked, pin_out.power_en}, 2'b01);
   endtask
   // Park, then keep clock and reset for the whole budget
   task automatic park;
      park_in = 1'b0;
      t = 0;
      while (parked !== 1'b1 && t < 2000) begin
         cyc(1);
         t++;
      end
      chk({t <= 320, pin_out.power_en}, 2'b10);
      cyc(300);
   endtask
   initial begin
      boot(8'h02);
      glitch;
      park;
      boot(8'h28);
      close_out;
   end
   // Whole run is near 1170 cycles
   initial begin
      #(40 * 5000);
      errors++;
      close_out;
   end
endmodule
